/* File: rtl/smc_pkg.sv */
package smc_pkg;

  // matrix geometry and change word layout
  localparam int unsigned ROWS_DEF       = 16;
  localparam int unsigned COLS           = 8;
  localparam int unsigned ROW_W          = 4;
  localparam int unsigned COL_W          = 3;
  localparam int unsigned WORD_W         = 8;
  localparam int unsigned CW_STATE_BIT   = 7;
  localparam int unsigned COL_CNT_W      = 4;
  localparam logic [3:0]  COL_PRESET     = 4'h8;
  localparam logic [3:0]  COL_IDLE       = 4'h0;

  // change word fifo
  localparam int unsigned FIFO_DEPTH_DEF = 40;

  // clock rate and timing
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned SCAN_TIME_US   = 2000;
  localparam int unsigned SCAN_CYCLES_DEF = SCAN_TIME_US * CLK_MHZ;
  // settle time of the row decoder and column returns, a least time so rounded up
  localparam int unsigned SETTLE_NS      = 30;
  localparam int unsigned SETTLE_CYCLES_DEF = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // edges from a pin change to the agreed synchroniser output
  localparam int unsigned SYNC_LAT       = 4;

  // scanner sequence
  typedef enum logic [2:0] {
    ST_SELECT,
    ST_SETTLE,
    ST_COMPARE,
    ST_SHIFT,
    ST_SERVICE,
    ST_WAIT
  } smc_state_type;

endpackage

/* File: rtl/smc_scanner.sv */
`timescale 1ns/100ps

module smc_scanner #(
  parameter int unsigned FIFO_DEPTH    = smc_pkg::FIFO_DEPTH_DEF,
  parameter int unsigned ROWS          = smc_pkg::ROWS_DEF,
  parameter int unsigned SCAN_CYCLES   = smc_pkg::SCAN_CYCLES_DEF,
  parameter int unsigned SETTLE_CYCLES = smc_pkg::SETTLE_CYCLES_DEF
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [smc_pkg::COLS-1:0]   column_return,
  output logic      [smc_pkg::ROW_W-1:0]  row_select,
  input  wire logic                       host_rd_stb,
  output logic      [smc_pkg::WORD_W-1:0] host_output_register,
  output logic                            output_full_flag,
  output logic                            change_ready_irq_pin,
  output logic                            fifo_nonempty_irq_pin
);
  import smc_pkg::*;

  localparam int unsigned PW  = $clog2(FIFO_DEPTH);
  localparam int unsigned CW  = $clog2(FIFO_DEPTH + 1);
  localparam int unsigned TW  = $clog2(SCAN_CYCLES + 1);
  localparam int unsigned SW  = $clog2(SETTLE_CYCLES + 1);
  localparam int unsigned RIW = $clog2(ROWS + 1);

  localparam logic [PW-1:0]  PTR_TOP    = PW'(FIFO_DEPTH - 1);
  localparam logic [CW-1:0]  CNT_FULL   = CW'(FIFO_DEPTH);
  localparam logic [TW-1:0]  TIMER_LAST = TW'(SCAN_CYCLES - 1);
  localparam logic [SW-1:0]  SETTLE_LAST = SW'(SETTLE_CYCLES - 1);
  localparam logic [RIW-1:0] ROW_END    = RIW'(ROWS);

  // parameter values the logic cannot serve
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("smc_scanner: fifo depth must be at least 2");
  end
  if (ROWS < 2 || ROWS > (1 << ROW_W)) begin : g_bad_rows
    $error("smc_scanner: row count does not fit the row field");
  end
  if (SCAN_CYCLES < 1) begin : g_bad_scan
    $error("smc_scanner: scan interval must be at least one cycle");
  end
  if (SETTLE_CYCLES < SYNC_LAT) begin : g_bad_settle
    $error("smc_scanner: settle time shorter than synchroniser latency");
  end

  // pointer step with wrap to the lowest entry
  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    if (p == PTR_TOP) begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  smc_state_type            state_q;
  smc_state_type            state_d;
  logic [RIW-1:0]           row_idx_q;
  logic [RIW-1:0]           row_idx_d;
  logic [ROW_W-1:0]         row_sel_q;
  logic [ROW_W-1:0]         row_sel_d;
  logic [TW-1:0]            timer_q;
  logic [TW-1:0]            timer_d;
  logic [SW-1:0]            settle_q;
  logic [SW-1:0]            settle_d;
  logic [COLS-1:0]          cmp_q;
  logic [COLS-1:0]          cmp_d;
  logic [COLS-1:0]          cur_q;
  logic [COLS-1:0]          cur_d;
  logic [COL_CNT_W-1:0]     col_q;
  logic [COL_CNT_W-1:0]     col_d;
  logic                     base_q;
  logic                     base_d;
  logic [PW-1:0]            wr_ptr_q;
  logic [PW-1:0]            rd_ptr_q;
  logic [CW-1:0]            cnt_q;
  logic [CW-1:0]            cnt_d;
  logic                     obf_q;
  logic                     fne_q;
  logic [WORD_W-1:0]        out_q;

  logic [WORD_W-1:0]        fifo_mem [FIFO_DEPTH];
  logic [COLS-1:0]          map_mem  [ROWS];

  wire logic [COLS-1:0]      col_sync;
  wire logic [ROW_W-1:0]     map_idx;
  wire logic [COLS-1:0]      map_prev;
  wire logic [COLS-1:0]      row_diff;
  wire logic                 fifo_full;
  wire logic                 fifo_empty;
  wire logic [COL_CNT_W-1:0] col_dec;
  wire logic [COL_W-1:0]     col_pos;
  wire logic [WORD_W-1:0]    change_word;
  wire logic                 map_wr;
  wire logic                 fifo_wr;
  wire logic                 xfer;
  wire logic                 in_service;

  // column returns arrive from pins and are synchronised first
  smc_sync #(
    .W        (COLS)
  ) u_col_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (column_return),
    .sync_out (col_sync)
  );

  assign map_idx  = row_idx_q[ROW_W-1:0];
  assign map_prev = map_mem[map_idx];
  assign row_diff = col_sync ^ map_prev;

  // fifo occupancy; an exact count keeps full and empty apart when pointers meet
  assign fifo_full  = (cnt_q == CNT_FULL);
  assign fifo_empty = (cnt_q == '0);

  assign col_dec     = col_q - 1'b1;
  assign col_pos     = col_dec[COL_W-1:0];
  assign change_word = {cur_q[col_pos], row_sel_q, col_pos};

  assign fifo_wr    = (state_q == ST_SHIFT) && cmp_q[COLS-1];
  assign map_wr     = (state_q == ST_COMPARE);
  assign in_service = (state_q == ST_SERVICE);

  assign xfer = in_service && !obf_q && !fifo_empty && (fifo_full || col_q == COL_IDLE);

  // scan sequence
  always_comb begin
    state_d   = state_q;
    row_idx_d = row_idx_q;
    row_sel_d = row_sel_q;
    timer_d   = timer_q;
    settle_d  = settle_q;
    cmp_d     = cmp_q;
    cur_d     = cur_q;
    col_d     = col_q;
    base_d    = base_q;
    case (state_q)
      ST_SELECT: begin
        if (row_idx_q == ROW_END) begin
          row_idx_d = '0;
          base_d    = 1'b0;
        end else begin
          row_sel_d = row_idx_q[ROW_W-1:0];
          settle_d  = '0;
          state_d   = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        settle_d = settle_q + 1'b1;
        if (settle_q == SETTLE_LAST) begin
          state_d = ST_COMPARE;
        end
      end
      ST_COMPARE: begin
        cur_d     = col_sync;
        cmp_d     = row_diff;
        row_idx_d = row_idx_q + 1'b1;
        if (base_q) begin
          state_d = ST_SELECT;
        end else if (row_diff == '0) begin
          col_d   = COL_IDLE;
          state_d = ST_SERVICE;
        end else begin
          col_d   = COL_PRESET;
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        col_d   = col_dec;
        cmp_d   = {cmp_q[COLS-2:0], 1'b0};
        state_d = ST_SERVICE;
      end
      ST_SERVICE: begin
        if (fifo_full) begin
          state_d = ST_SERVICE;
        end else if (col_q != COL_IDLE) begin
          state_d = ST_SHIFT;
        end else if (!xfer) begin
          timer_d = '0;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        timer_d = timer_q + 1'b1;
        if (timer_q == TIMER_LAST) begin
          state_d = ST_SELECT;
        end
      end
      default: begin
        state_d = ST_SELECT;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q   <= ST_SELECT;
      row_idx_q <= '0;
      row_sel_q <= '0;
      base_q    <= 1'b1;
    end else begin
      state_q   <= state_d;
      row_idx_q <= row_idx_d;
      row_sel_q <= row_sel_d;
      base_q    <= base_d;
    end
  end

  // scan counters and row working registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_q  <= '0;
      settle_q <= '0;
      cmp_q    <= '0;
      cur_q    <= '0;
      col_q    <= COL_IDLE;
    end else begin
      timer_q  <= timer_d;
      settle_q <= settle_d;
      cmp_q    <= cmp_d;
      cur_q    <= cur_d;
      col_q    <= col_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (map_wr) begin
      map_mem[map_idx] <= col_sync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (fifo_wr) begin
      fifo_mem[wr_ptr_q] <= change_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (fifo_wr) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (xfer) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
    end
  end

  // occupancy count; write and transfer never meet since they use different states
  assign cnt_d = cnt_q + CW'(fifo_wr) - CW'(xfer);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_q <= '0;
    end else if (xfer) begin
      out_q <= fifo_mem[rd_ptr_q];
    end
  end

  // set on load, clear on host read
  // loads only happen while clear, so a read and a load never collide
  always_ff @(posedge core_clk) begin
    if (rst) begin
      obf_q <= 1'b0;
    end else begin
      obf_q <= xfer | (obf_q & ~host_rd_stb);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fne_q <= 1'b0;
    end else if (in_service) begin
      fne_q <= (cnt_d != '0);
    end
  end

  // outputs straight from registers
  assign row_select           = row_sel_q;
  assign host_output_register = out_q;
  assign output_full_flag     = obf_q;
  assign change_ready_irq_pin = obf_q;
  assign fifo_nonempty_irq_pin = fne_q;

endmodule // smc_scanner

/* File: rtl/smc_sync.sv */
`timescale 1ns/100ps

module smc_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] agree;

  // three stage chain; the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // a bit is taken over only once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q <= (s3_q & agree) | (out_q & ~agree);
    end
  end

  assign sync_out = out_q;

endmodule // smc_sync

/* File: tb/sensor_matrix_change_scanner_test.sv */
`timescale 1ns/100ps

module sensor_matrix_change_scanner_test;
  import smc_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] column_return = 8'h00;
  logic       read_en = 1'b1;
  logic [3:0] row_select;
  logic       host_rd_stb;
  logic [7:0] host_output_register;
  logic       output_full_flag;
  logic       change_ready_irq_pin;
  logic       fifo_nonempty_irq_pin;
  logic [7:0] word_q;
  logic       got_q;
  logic [7:0] mat [16];
  logic [7:0] got_list [$];
  int         err_count = 0;
  int         tests_run = 0;

  always #2.5 core_clk = ~core_clk;

  // the selected row answers on the column returns
  always @(posedge core_clk) column_return <= mat[row_select];
  always @(posedge core_clk) if (got_q === 1'b1) got_list.push_back(word_q);

  smc_scanner #(.FIFO_DEPTH(4), .ROWS(16), .SCAN_CYCLES(20), .SETTLE_CYCLES(6)) dut (
    .core_clk(core_clk), .rst(rst), .column_return(column_return), .row_select(row_select),
    .host_rd_stb(host_rd_stb), .host_output_register(host_output_register), .output_full_flag(output_full_flag),
    .change_ready_irq_pin(change_ready_irq_pin), .fifo_nonempty_irq_pin(fifo_nonempty_irq_pin));

  smc_host_model host (.core_clk(core_clk), .rst(rst), .read_en(read_en), .change_ready_irq_pin(change_ready_irq_pin),
    .host_output_register(host_output_register), .host_rd_stb(host_rd_stb), .word_q(word_q), .got_q(got_q));

  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // expected change word: present level, row, column
  function automatic logic [7:0] cw(int r, int c);
    return {mat[r][c], 4'(r), 3'(c)};
  endfunction

  // change a row only while another row is selected, so no sample is torn
  task flip(input int r, input logic [7:0] m);
    @(posedge core_clk);
    while (row_select == 4'(r)) @(posedge core_clk);
    mat[r] <= mat[r] ^ m;
    @(posedge core_clk);
  endtask

  // bounded wait until the host has n words
  task drain(input int n);
    int k;
    k = 0;
    read_en <= 1'b1;
    while (got_list.size() < n && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    check(8'(got_list.size()), 8'(n));
  endtask

  task t_reset;
    check({row_select, output_full_flag, change_ready_irq_pin, fifo_nonempty_irq_pin, 1'b0}, 8'h00);
    check(host_output_register, 8'h00);
    rst <= 1'b0;
    repeat (1200) @(posedge core_clk);
    check(8'(got_list.size()), 8'h00);
    $display("done reset baseline");
  endtask

  task t_single;
    flip(5, 8'h04);
    drain(1);
    check(got_list.pop_front(), cw(5, 2));
    $display("done single change");
  endtask

  task t_multi;
    flip(3, 8'h81);
    drain(2);
    check(got_list.pop_front(), cw(3, 7));
    check(got_list.pop_front(), cw(3, 0));
    $display("done two changes");
  endtask

  task t_full;
    int c;
    read_en <= 1'b0;
    flip(9, 8'hFF);
    repeat (300) @(posedge core_clk);
    check(8'(change_ready_irq_pin), 8'h01);
    check(8'(fifo_nonempty_irq_pin), 8'h01);
    repeat (200) @(posedge core_clk);
    check(8'(row_select), 8'h09);
    drain(8);
    for (c = 7; c >= 0; c--) begin
      check(got_list.pop_front(), cw(9, c));
    end
    repeat (100) @(posedge core_clk);
    check(8'(fifo_nonempty_irq_pin), 8'h00);
    $display("done fifo full");
  endtask

  // watchdog sized well above the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim;
  end

  initial begin
    for (int i = 0; i < 16; i++) mat[i] = 8'(i * 37);
    repeat (12) @(posedge core_clk);
    t_reset;
    t_single;
    t_multi;
    t_full;
    end_sim;
  end
endmodule // sensor_matrix_change_scanner_test

/* File: tb/smc_host_model.sv */
`timescale 1ns/100ps

module smc_host_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       read_en,
  input  wire logic       change_ready_irq_pin,
  input  wire logic [7:0] host_output_register,
  output logic            host_rd_stb,
  output logic [7:0]      word_q,
  output logic            got_q
);
  // read_en low makes a slow host that leaves the word unread
  // poll then read
  always_ff @(posedge core_clk) begin
    got_q <= 1'b0;
    if (rst) begin
      host_rd_stb <= 1'b0;
    end else if (host_rd_stb) begin
      host_rd_stb <= 1'b0;
      word_q      <= host_output_register;
      got_q       <= 1'b1;
    end else if (read_en && change_ready_irq_pin) begin
      host_rd_stb <= 1'b1;
    end
  end
endmodule // smc_host_model

/* File: tb/smc_monitor.sv */
`timescale 1ns/100ps

module smc_monitor #(
  parameter int unsigned SCAN_CYCLES   = 20,
  parameter int unsigned SETTLE_CYCLES = 6
) (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic [smc_pkg::COLS-1:0]   column_return,
  input wire logic [smc_pkg::ROW_W-1:0]  row_select,
  input wire logic                       host_rd_stb,
  input wire logic [smc_pkg::WORD_W-1:0] host_output_register,
  input wire logic                       output_full_flag,
  input wire logic                       change_ready_irq_pin,
  input wire logic                       fifo_nonempty_irq_pin
);
  import smc_pkg::*;
  // worst wait from a read to the next transfer: scan wait, row wrap, settle, compare,
  // then a changed row runs all its bit tests before the output may be reloaded
  localparam int RELOAD_MAX = SCAN_CYCLES + SETTLE_CYCLES + 2 * COLS + 8;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // host read of a loaded register while words wait in the fifo
  sequence s_read;
    output_full_flag && host_rd_stb && fifo_nonempty_irq_pin;
  endsequence
  sequence s_reload;
    !output_full_flag ##[0:RELOAD_MAX] output_full_flag;
  endsequence

  property p_reset_state;
    $fell(rst) |-> row_select == 4'h0 && host_output_register == 8'h00 && !output_full_flag && !fifo_nonempty_irq_pin;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("outputs not cleared by reset");
  property p_irq_follows;
    change_ready_irq_pin == output_full_flag;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("change ready pin differs from flag");
  property p_read_clears;
    output_full_flag && host_rd_stb |=> !output_full_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("host read did not clear flag");
  property p_flag_holds;
    output_full_flag && !host_rd_stb |=> output_full_flag && $stable(host_output_register);
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("unread word lost");
  property p_load_sets;
    $changed(host_output_register) |-> $rose(output_full_flag);
  endproperty
  a_load_sets: assert property (p_load_sets) else $error("output loaded without flag set");
  property p_reload;
    s_read |=> s_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("waiting word not moved out");
  property p_row_order;
    $changed(row_select) |-> row_select == $past(row_select) + 4'h1;
  endproperty
  a_row_order: assert property (p_row_order) else $error("row order broken");
  property p_row_stands;
    $changed(row_select) |=> $stable(row_select) [*6];
  endproperty
  a_row_stands: assert property (p_row_stands) else $error("row changed before sample");
endmodule // smc_monitor

bind smc_scanner smc_monitor #(.SCAN_CYCLES(SCAN_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
  .core_clk(core_clk), .rst(rst), .column_return(column_return), .row_select(row_select),
  .host_rd_stb(host_rd_stb), .host_output_register(host_output_register), .output_full_flag(output_full_flag),
  .change_ready_irq_pin(change_ready_irq_pin), .fifo_nonempty_irq_pin(fifo_nonempty_irq_pin));
